// ===== logic/pbol_latch.sv
`default_nettype none
module pbol_latch
  import pbol_pkg::*;
#(
  parameter bit P_VARIANT_B = 1'b0,
  parameter int unsigned P_TICK_CYCLES = TICK_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // pins from the switch and the system
  input wire logic i_button_in_n,
  input wire logic i_force_off_n,
  // power enable
  output logic o_power_on,
  // alert, open drain
  output logic o_alert_n_o,
  output logic o_alert_n_oe
);

  localparam pbol_timing_s TIMING = P_VARIANT_B ? TIMING_B : TIMING_A;

  pbol_state_e state;
  pbol_state_e next_state;
  pbol_evt_s evt;
  logic btn_meta;
  logic btn_sync;
  logic clr_meta;
  logic clr_sync;
  logic latch;
  logic alert_on;
  logic [PRESS_W-1:0] press_ticks;
  logic [ALERT_W-1:0] alert_left;
  logic [LOCK_W-1:0] lock_left;
  wire logic tick;
  wire logic btn_low;
  wire logic press_start;
  wire logic lockout;
  wire logic clear_ok;
  wire logic long_clear;
  wire logic latch_set;

  // two-flop synchronisers on the pins
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      btn_meta <= PIN_IDLE_RST;
      btn_sync <= PIN_IDLE_RST;
      clr_meta <= PIN_IDLE_RST;
      clr_sync <= PIN_IDLE_RST;
    end else begin
      btn_meta <= i_button_in_n;
      btn_sync <= btn_meta;
      clr_meta <= i_force_off_n;
      clr_sync <= clr_meta;
    end
  end

  // press decode
  assign btn_low = !btn_sync;
  assign press_start = (state == PBOL_IDLE) && btn_low;

  // one time base for every interval
  pbol_timebase #(
    .P_TICK_CYCLES(P_TICK_CYCLES)
  ) u_timebase (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_restart(press_start),
    .o_tick(tick)
  );

  // events at the ends of debounce and hold-off
  assign evt.debounced = (state == PBOL_QUAL) && btn_low && tick &&
    (press_ticks == TIMING.debounce_interval - 1'b1);
  assign evt.long_hold = (state == PBOL_HELD) && btn_low && tick &&
    (press_ticks == TIMING.holdoff_interval - 1'b1);

  // latch control
  assign lockout = (lock_left != LOCK_RST);
  // a debounce event in the same cycle wins over the clear
  assign clear_ok = latch && !clr_sync && !lockout && !evt.debounced;
  assign long_clear = evt.long_hold && !P_VARIANT_B;
  assign latch_set = evt.debounced && !latch;

  // press state sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      PBOL_IDLE: begin
        if (btn_low) begin
          next_state = PBOL_QUAL;
        end
      end
      PBOL_QUAL: begin
        if (!btn_low) begin
          next_state = PBOL_IDLE;
        end else if (evt.debounced) begin
          next_state = PBOL_HELD;
        end
      end
      PBOL_HELD: begin
        if (!btn_low) begin
          next_state = PBOL_IDLE;
        end else if (evt.long_hold) begin
          next_state = PBOL_LONG;
        end
      end
      PBOL_LONG: begin
        if (!btn_low) begin
          next_state = PBOL_IDLE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= PBOL_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // closure length in ticks, zeroed at each new press
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      press_ticks <= PRESS_RST;
    end else if (press_start) begin
      press_ticks <= PRESS_RST;
    end else if (tick && (state != PBOL_LONG)) begin
      press_ticks <= press_ticks + 1'b1;
    end
  end

  // power latch
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      latch <= 1'b0;
    end else if (latch_set) begin
      latch <= 1'b1;
    end else if (long_clear || clear_ok) begin
      latch <= 1'b0;
    end
  end

  // clear lockout after turn-on
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lock_left <= LOCK_RST;
    end else if (latch_set) begin
      lock_left <= LOCKOUT_TICKS;
    end else if (tick && lockout) begin
      lock_left <= lock_left - 1'b1;
    end
  end

  // alert pulse timer, untouched by the clear pin
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      alert_left <= ALERT_RST;
      alert_on <= 1'b0;
    end else if (evt.long_hold) begin
      alert_left <= ALERT_LONG_TICKS;
      alert_on <= 1'b1;
    end else if (evt.debounced) begin
      alert_left <= ALERT_TICKS;
      alert_on <= 1'b1;
    end else if (tick && alert_on) begin
      alert_left <= alert_left - 1'b1;
      alert_on <= (alert_left != 8'h01);
    end
  end

  // outputs
  assign o_power_on = latch;
  assign o_alert_n_o = 1'b0;
  assign o_alert_n_oe = alert_on;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  idle_needs_low_a: assert property (state == PBOL_IDLE && !btn_low |=> state == PBOL_IDLE)
    else $error("press started without low input");
  debounce_sets_a: assert property (evt.debounced |=> o_power_on)
    else $error("latch not set after debounce");
  long_clears_a: assert property (evt.long_hold && !P_VARIANT_B |=> !o_power_on)
    else $error("variant A latch kept after long hold");
  short_keeps_a: assert property ($fell(latch) |-> $past(long_clear || clear_ok))
    else $error("latch fell without cause");
  variant_b_keeps_a: assert property (evt.long_hold && P_VARIANT_B && latch |=> latch)
    else $error("variant B latch cleared by long hold");
  alert_short_a: assert property (evt.debounced |=> alert_on && alert_left == ALERT_TICKS)
    else $error("short alert not started");
  alert_long_a: assert property (evt.long_hold |=> o_alert_n_oe && alert_left == ALERT_LONG_TICKS)
    else $error("long alert not started");
  no_retrigger_a: assert property ($rose(alert_on) |-> $past(evt.debounced || evt.long_hold))
    else $error("alert started without an event");
  lockout_hold_a: assert property (lockout && latch && !long_clear |=> latch)
    else $error("clear acted during lockout");
  clear_off_a: assert property (!latch && !evt.debounced |=> !latch)
    else $error("latch rose without debounce");
  clear_no_alert_a: assert property (!tick && evt == 2'b00 |=> $stable(alert_left))
    else $error("alert timer moved without tick");
  clear_forces_a: assert property (clear_ok |=> !o_power_on)
    else $error("clear did not force latch off");
  release_restarts_a: assert property (state == PBOL_QUAL && !btn_low |=> state == PBOL_IDLE)
    else $error("release did not restart debounce");
  alert_drain_a: assert property (o_alert_n_oe |-> o_alert_n_o == 1'b0)
    else $error("alert drives high");
  tick_paces_a: assert property (!tick && !press_start |=> $stable(press_ticks))
    else $error("press timer moved without tick");
  press_zeroes_a: assert property (press_start |=> press_ticks == PRESS_RST)
    else $error("press timer not zeroed");

  debounce_seen_c: cover property (evt.debounced);
  long_seen_c: cover property (evt.long_hold);
  clear_seen_c: cover property (clear_ok);
  bounce_seen_c: cover property (state == PBOL_QUAL ##1 state == PBOL_IDLE);

endmodule : pbol_latch
`default_nettype wire

// ===== logic/pbol_pkg.sv
`default_nettype none
package pbol_pkg;

  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W = 17;
  localparam int unsigned TICK_MS = 1;

  // intervals in milliseconds, debounce and hold-off per variant
  localparam int unsigned DEBOUNCE_A_MS = 50;
  localparam int unsigned HOLDOFF_A_MS = 8000;
  localparam int unsigned DEBOUNCE_B_MS = 2000;
  localparam int unsigned HOLDOFF_B_MS = 16000;
  localparam int unsigned ALERT_MS = 32;
  localparam int unsigned ALERT_LONG_FACTOR = 4;
  localparam int unsigned LOCKOUT_FACTOR = 2;

  // counter widths
  localparam int unsigned PRESS_W = 15;
  localparam int unsigned ALERT_W = 8;
  localparam int unsigned LOCK_W = 7;

  // intervals in time-base ticks
  localparam logic [PRESS_W-1:0] DEBOUNCE_A_TICKS = PRESS_W'(DEBOUNCE_A_MS / TICK_MS);
  localparam logic [PRESS_W-1:0] HOLDOFF_A_TICKS = PRESS_W'(HOLDOFF_A_MS / TICK_MS);
  localparam logic [PRESS_W-1:0] DEBOUNCE_B_TICKS = PRESS_W'(DEBOUNCE_B_MS / TICK_MS);
  localparam logic [PRESS_W-1:0] HOLDOFF_B_TICKS = PRESS_W'(HOLDOFF_B_MS / TICK_MS);
  localparam logic [ALERT_W-1:0] ALERT_TICKS = ALERT_W'(ALERT_MS / TICK_MS);
  localparam logic [ALERT_W-1:0] ALERT_LONG_TICKS =
    ALERT_W'(ALERT_LONG_FACTOR * ALERT_MS / TICK_MS);
  localparam logic [LOCK_W-1:0] LOCKOUT_TICKS = LOCK_W'(LOCKOUT_FACTOR * ALERT_MS / TICK_MS);

  // reset values
  localparam logic PIN_IDLE_RST = 1'b1;
  localparam logic [PRESS_W-1:0] PRESS_RST = 15'h0000;
  localparam logic [ALERT_W-1:0] ALERT_RST = 8'h00;
  localparam logic [LOCK_W-1:0] LOCK_RST = 7'h00;

  // press states
  typedef enum logic [1:0] {
    PBOL_IDLE,
    PBOL_QUAL,
    PBOL_HELD,
    PBOL_LONG
  } pbol_state_e;

  // timing set of one variant
  typedef struct packed {
    logic [PRESS_W-1:0] debounce_interval;
    logic [PRESS_W-1:0] holdoff_interval;
  } pbol_timing_s;

  localparam pbol_timing_s TIMING_A = '{DEBOUNCE_A_TICKS, HOLDOFF_A_TICKS};
  localparam pbol_timing_s TIMING_B = '{DEBOUNCE_B_TICKS, HOLDOFF_B_TICKS};

  // press events of one cycle
  typedef struct packed {
    logic debounced;
    logic long_hold;
  } pbol_evt_s;

endpackage : pbol_pkg
`default_nettype wire

// ===== logic/pbol_timebase.sv
`default_nettype none
module pbol_timebase
  import pbol_pkg::*;
#(
  parameter int unsigned P_TICK_CYCLES = TICK_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // control
  input wire logic i_restart,
  // time base
  output logic o_tick
);

  logic [TICK_CNT_W-1:0] cnt;
  wire logic at_last;

  // terminal count of the divider
  assign at_last = (cnt == TICK_CNT_W'(P_TICK_CYCLES - 1));
  assign o_tick = at_last && !i_restart;

  // free-running divider, realigned at each new press
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= '0;
    end else if (i_restart || at_last) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

endmodule : pbol_timebase
`default_nettype wire

// ===== tb/pbol_switch_model.sv
`default_nettype none
module pbol_switch_model #(
  parameter int unsigned P_BOUNCE = 6
) (
  // clock
  input wire logic i_clk,
  // contact command from the bench
  input wire logic i_close,
  // switch pin, pulled up when open
  output logic o_button_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last;
  int unsigned left;
  initial begin
    o_button_n = 1'b1;
    last = 1'b0;
    left = 0;
  end
  // contact chatters one level per cycle before it settles
  always @(posedge i_clk) begin
    if (i_close != last) begin
      last <= i_close;
      left <= P_BOUNCE;
    end else if (left != 0) begin
      left <= left - 1;
      o_button_n <= ~o_button_n;
    end else begin
      o_button_n <= ~last;
    end
  end
endmodule : pbol_switch_model
`default_nettype wire

// ===== tb/tb.sv
`default_nettype none
module tb
  import pbol_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 4;
  localparam int SETTLE = 8;
  localparam int DB = DEBOUNCE_A_MS * T;
  localparam int DBB = DEBOUNCE_B_MS * T;
  localparam int HA = HOLDOFF_A_MS * T;
  localparam int HB = HOLDOFF_B_MS * T;
  localparam int AL = ALERT_MS * T;
  localparam int AL4 = ALERT_LONG_FACTOR * ALERT_MS * T;
  localparam int LK = LOCKOUT_FACTOR * ALERT_MS * T;
  logic i_clk, i_rstn, close, force_off_n, button_n;
  logic power_a, power_b, al_o_a, al_oe_a, al_o_b, al_oe_b;
  wire logic pin_a = al_oe_a ? al_o_a : 1'b1;
  int fails, comparisons, n_a, n_b;

  pbol_switch_model u_sw (.i_clk(i_clk), .i_close(close), .o_button_n(button_n));
  pbol_latch #(.P_VARIANT_B(1'b0), .P_TICK_CYCLES(T)) u_dut (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_button_in_n(button_n), .i_force_off_n(force_off_n), .o_power_on(power_a),
    .o_alert_n_o(al_o_a), .o_alert_n_oe(al_oe_a));
  pbol_latch #(.P_VARIANT_B(1'b1), .P_TICK_CYCLES(T)) u_dut_b (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_button_in_n(button_n), .i_force_off_n(force_off_n), .o_power_on(power_b),
    .o_alert_n_o(al_o_b), .o_alert_n_oe(al_oe_b));

  // free running clock
  always #4 i_clk = ~i_clk;

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step

  task automatic chk_bit(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_count(input string name, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      fails++;
      $display("ERROR %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_count

  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic t_reset;
    chk_bit("power_a", 1'b0, power_a);
    chk_bit("power_b", 1'b0, power_b);
    chk_bit("alert_pin", 1'b1, pin_a);
    chk_bit("alert_data", 1'b0, al_o_a);
    chk_bit("alert_data_b", 1'b0, al_o_b);
    $display("test reset done");
  endtask : t_reset

  // closure broken off before the debounce end
  task automatic t_glitch;
    close = 1'b1;
    step(SETTLE + DB - 10 * T);
    close = 1'b0;
    step(SETTLE + DB);
    chk_bit("power_a", 1'b0, power_a);
    chk_bit("alert_pin", 1'b1, pin_a);
    $display("test glitch done");
  endtask : t_glitch

  // short press, clear in lockout, clear after lockout, clear while off
  task automatic t_short;
    close = 1'b1;
    step(SETTLE + DB - 2);
    chk_bit("power_a", 1'b0, power_a);
    step(6);
    chk_bit("power_a", 1'b1, power_a);
    chk_bit("alert_pin", 1'b0, pin_a);
    force_off_n = 1'b0;
    step(AL - 6);
    chk_bit("alert_pin", 1'b0, pin_a);
    chk_bit("power_a", 1'b1, power_a);
    step(6);
    chk_bit("alert_pin", 1'b1, pin_a);
    force_off_n = 1'b1;
    close = 1'b0;
    step(SETTLE + 4);
    chk_bit("power_a", 1'b1, power_a);
    chk_bit("power_b", 1'b0, power_b);
    step(LK - AL - 10);
    force_off_n = 1'b0;
    // release bounces realign the time base, so lockout ends a few cycles late
    step(4 + 3 * T);
    chk_bit("power_a", 1'b0, power_a);
    step(2 * T);
    chk_bit("power_a", 1'b0, power_a);
    chk_bit("alert_pin", 1'b1, pin_a);
    force_off_n = 1'b1;
    $display("test short done");
  endtask : t_short

  // long hold on both variants, alert cycles counted throughout
  task automatic t_long;
    n_a = 0;
    n_b = 0;
    close = 1'b1;
    step(SETTLE);
    for (int i = 1; i <= HB + AL4 + 40 * T; i++) begin
      step(1);
      n_a += (al_oe_a === 1'b1);
      n_b += (al_oe_b === 1'b1);
      if (i == HA - 2) chk_bit("power_a", 1'b1, power_a);
      if (i == HA + 6) chk_bit("power_a", 1'b0, power_a);
      if (i == DBB + 6) chk_bit("power_b", 1'b1, power_b);
    end
    chk_bit("power_b", 1'b1, power_b);
    chk_count("alert_cycles_a", AL + AL4, n_a);
    chk_count("alert_cycles_b", AL + AL4, n_b);
    close = 1'b0;
    step(SETTLE + 4);
    $display("test long done");
  endtask : t_long

  // new press timed from zero again
  task automatic t_repress;
    close = 1'b1;
    step(SETTLE + DB - 2);
    chk_bit("power_a", 1'b0, power_a);
    step(6);
    chk_bit("power_a", 1'b1, power_a);
    chk_bit("alert_pin", 1'b0, pin_a);
    close = 1'b0;
    step(SETTLE);
    $display("test repress done");
  endtask : t_repress

  // main sequence
  initial begin
    i_clk = 1'b0;
    i_rstn = 1'b0;
    close = 1'b0;
    force_off_n = 1'b1;
    fails = 0;
    comparisons = 0;
    step(5);
    i_rstn = 1'b1;
    step(1);
    t_reset();
    t_glitch();
    t_short();
    t_long();
    t_repress();
    report_and_stop();
  end

  // hang guard
  initial begin
    #800000;
    fails++;
    $display("ERROR watchdog expected finish seen timeout");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
